// *** fifo_link_list_indirect_config.sv ***
// indirect-access register bank for the fifo link-list tables
//
// Chosen here: the AHB-Lite slave port.
module fifo_link_list_indirect_config
  import fifo_link_pkg::*;
(
  // clock and reset
  input  wire logic                       hclk,
  input  wire logic                       hresetn,
  // ahb-lite slave
  input  wire fifo_link_pkg::ahb_in_type  ahb_in,
  output fifo_link_pkg::ahb_out_type      ahb_out,
  // receive engine side
  input  wire fifo_link_pkg::rx_event_type rx_event,
  input  wire logic [7:0]                 rx_lookup_channel,
  output logic [9:0]                      rx_lookup_block,
  output fifo_link_pkg::rx_xfer_type      rx_xfer,
  // transmit engine side
  input  wire fifo_link_pkg::tx_event_type tx_event,
  input  wire logic [7:0]                 tx_lookup_channel,
  output logic [9:0]                      tx_lookup_block
);
  import fifo_link_pkg::*;

  typedef struct packed {
    bus_state_type                        bus_state;
    slot_type                             slot;
    logic [31:0]                          hrdata;
    logic [NUM_TABLES-1:0][BLOCK_W-1:0]   index;
    logic [NUM_TABLES-1:0]                dir;
    logic [NUM_TABLES-1:0]                busy;
    logic [NUM_TABLES-1:0][BLOCK_W-1:0]   data;
    logic                                 xfer_req;
    logic [CHAN_W-1:0]                    xfer_channel;
    logic [BLOCK_W-1:0]                   rx_lookup;
    logic [BLOCK_W-1:0]                   tx_lookup;
  } state_type;

  state_type state;
  state_type next_state;

  // table storage; no reset, software must program it before use
  logic [BLOCK_W-1:0] rx_cur_mem   [NUM_CHAN];
  logic [BLOCK_W-1:0] rx_next_mem  [NUM_BLOCKS];
  logic [BLOCK_W-1:0] rx_high_mem  [NUM_CHAN];
  logic [BLOCK_W-1:0] rx_count_mem [NUM_CHAN];
  logic [BLOCK_W-1:0] tx_cur_mem   [NUM_CHAN];

  logic [NUM_TABLES-1:0][BLOCK_W-1:0] table_rd;
  logic [NUM_TABLES-1:0]              conflict;
  logic [NUM_TABLES-1:0]              table_we;
  logic [BLOCK_W-1:0]                 rx_cur_now;
  logic [BLOCK_W-1:0]                 rx_following;
  logic [BLOCK_W-1:0]                 rx_count_inc;
  logic                               rx_mark_hit;
  logic                               rx_count_we;
  logic [BLOCK_W-1:0]                 tx_cur_now;
  logic [BLOCK_W-1:0]                 tx_following;
  logic                               addr_take;

  function automatic slot_type reg_slot(input logic [31:0] addr);
    slot_type s;
    s = '0;
    case (addr)
      RX_START_SEL_ADDR:  s = '{1'b1, 1'b0, TBL_RX_START};
      RX_START_DATA_ADDR: s = '{1'b1, 1'b1, TBL_RX_START};
      RX_NEXT_SEL_ADDR:   s = '{1'b1, 1'b0, TBL_RX_NEXT};
      RX_NEXT_DATA_ADDR:  s = '{1'b1, 1'b1, TBL_RX_NEXT};
      RX_HIGH_SEL_ADDR:   s = '{1'b1, 1'b0, TBL_RX_HIGH};
      RX_HIGH_DATA_ADDR:  s = '{1'b1, 1'b1, TBL_RX_HIGH};
      TX_START_SEL_ADDR:  s = '{1'b1, 1'b0, TBL_TX_START};
      TX_START_DATA_ADDR: s = '{1'b1, 1'b1, TBL_TX_START};
      default:            s = '0;
    endcase
    return s;
  endfunction

  // per-channel tables keep only an 8-bit index, block table keeps 10
  function automatic logic [BLOCK_W-1:0] index_mask(input logic [1:0] tbl);
    return (tbl == TBL_RX_NEXT) ? BLOCK_MASK : CHAN_MASK;
  endfunction

  // table reads for pending indirect accesses
  assign table_rd[TBL_RX_START] =
    rx_cur_mem[state.index[TBL_RX_START][CHAN_W-1:0]];
  assign table_rd[TBL_RX_NEXT]  = rx_next_mem[state.index[TBL_RX_NEXT]];
  assign table_rd[TBL_RX_HIGH]  =
    rx_high_mem[state.index[TBL_RX_HIGH][CHAN_W-1:0]];
  assign table_rd[TBL_TX_START] =
    tx_cur_mem[state.index[TBL_TX_START][CHAN_W-1:0]];

  // engine pointer walking along the chain
  assign rx_cur_now   = rx_cur_mem[rx_event.channel];
  assign rx_following = rx_next_mem[rx_cur_now];
  assign rx_count_inc = rx_count_mem[rx_event.channel] + COUNT_STEP;
  assign rx_mark_hit  = rx_event.block_done &&
                        (rx_count_inc >= rx_high_mem[rx_event.channel]);
  assign rx_count_we  = rx_event.block_done || rx_event.eof;
  assign tx_cur_now   = tx_cur_mem[tx_event.channel];
  // transmit next-pointer table lives elsewhere; the cursor steps linearly
  assign tx_following = tx_cur_now + COUNT_STEP;

  // an engine step on the same table defers the host access one cycle
  assign conflict[TBL_RX_START] = rx_event.block_done;
  assign conflict[TBL_RX_NEXT]  = 1'b0;
  assign conflict[TBL_RX_HIGH]  = 1'b0;
  assign conflict[TBL_TX_START] = tx_event.block_done;

  genvar g;
  generate
    for (g = 0; g < NUM_TABLES; g++) begin : gen_we
      assign table_we[g] = state.busy[g] && !state.dir[g] &&
                           !conflict[g];
    end
  endgenerate

  assign addr_take = ahb_in.hsel && ahb_in.htrans[1] && ahb_in.hready &&
                     (state.bus_state != BUS_READ_WAIT);

  always_comb begin
    next_state = state;
    next_state.xfer_req = 1'b0;

    // data phase of a write
    if (state.bus_state == BUS_WRITE && state.slot.hit) begin
      if (state.slot.is_data) begin
        next_state.data[state.slot.tbl] = ahb_in.hwdata[BLOCK_W-1:0];
      end else if (!state.busy[state.slot.tbl]) begin
        // a select written while busy is dropped so the running access
        // keeps its location
        next_state.index[state.slot.tbl] =
          ahb_in.hwdata[BLOCK_W-1:0] & index_mask(state.slot.tbl);
        next_state.dir[state.slot.tbl]  = ahb_in.hwdata[DIR_BIT];
        next_state.busy[state.slot.tbl] = 1'b1;
      end
    end

    // first data-phase cycle of a read builds the word
    if (state.bus_state == BUS_READ_WAIT) begin
      if (!state.slot.hit) begin
        next_state.hrdata = 32'h0000_0000;
      end else if (state.slot.is_data) begin
        next_state.hrdata = {22'h00_0000, state.data[state.slot.tbl]};
      end else begin
        next_state.hrdata = {16'h0000, state.busy[state.slot.tbl],
                             state.dir[state.slot.tbl], 4'h0,
                             state.index[state.slot.tbl]};
      end
    end

    // indirect accesses finish one cycle after the select write
    for (int t = 0; t < NUM_TABLES; t++) begin
      if (state.busy[t] && !conflict[t]) begin
        if (state.dir[t]) begin
          next_state.data[t] = table_rd[t];
        end
        next_state.busy[t] = 1'b0;
      end
    end

    // bus sequencing
    case (state.bus_state)
      BUS_READ_WAIT: begin
        next_state.bus_state = BUS_READ_DONE;
      end
      BUS_IDLE, BUS_WRITE, BUS_READ_DONE: begin
        if (addr_take) begin
          next_state.slot      = reg_slot(ahb_in.haddr);
          next_state.bus_state = ahb_in.hwrite ? BUS_WRITE : BUS_READ_WAIT;
        end else begin
          next_state.bus_state = BUS_IDLE;
        end
      end
      default: begin
        next_state.bus_state = BUS_IDLE;
      end
    endcase

    // transfer request on high mark or end of frame
    if (rx_mark_hit || rx_event.eof) begin
      next_state.xfer_req     = 1'b1;
      next_state.xfer_channel = rx_event.channel;
    end

    next_state.rx_lookup = rx_cur_mem[rx_lookup_channel];
    next_state.tx_lookup = tx_cur_mem[tx_lookup_channel];
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  // receive current pointer: host write sets the start, engine advances it
  always_ff @(posedge hclk) begin
    if (table_we[TBL_RX_START]) begin
      rx_cur_mem[state.index[TBL_RX_START][CHAN_W-1:0]] <=
        state.data[TBL_RX_START];
    end else if (rx_event.block_done) begin
      rx_cur_mem[rx_event.channel] <= rx_following;
    end
  end

  always_ff @(posedge hclk) begin
    if (table_we[TBL_RX_NEXT]) begin
      rx_next_mem[state.index[TBL_RX_NEXT]] <=
        state.data[TBL_RX_NEXT];
    end
  end

  always_ff @(posedge hclk) begin
    if (table_we[TBL_RX_HIGH]) begin
      rx_high_mem[state.index[TBL_RX_HIGH][CHAN_W-1:0]] <=
        state.data[TBL_RX_HIGH];
    end
  end

  // block count restarts when the start pointer is reprogrammed
  always_ff @(posedge hclk) begin
    if (table_we[TBL_RX_START]) begin
      rx_count_mem[state.index[TBL_RX_START][CHAN_W-1:0]] <= COUNT_ZERO;
    end else if (rx_count_we) begin
      rx_count_mem[rx_event.channel] <=
        (rx_mark_hit || rx_event.eof) ? COUNT_ZERO : rx_count_inc;
    end
  end

  always_ff @(posedge hclk) begin
    if (table_we[TBL_TX_START]) begin
      tx_cur_mem[state.index[TBL_TX_START][CHAN_W-1:0]] <=
        state.data[TBL_TX_START];
    end else if (tx_event.block_done) begin
      tx_cur_mem[tx_event.channel] <= tx_following;
    end
  end

  assign ahb_out.hreadyout   = (state.bus_state != BUS_READ_WAIT);
  assign ahb_out.hresp       = HRESP_OKAY;
  assign ahb_out.hrdata      = state.hrdata;
  assign rx_xfer.req         = state.xfer_req;
  assign rx_xfer.channel     = state.xfer_channel;
  assign rx_lookup_block     = state.rx_lookup;
  assign tx_lookup_block     = state.tx_lookup;

endmodule

// *** fifo_link_pkg.sv ***
// constants and types for the fifo link-list indirect configuration bank
package fifo_link_pkg;

  // register byte addresses
  localparam logic [31:0] RX_START_SEL_ADDR  = 32'h0000_0900;
  localparam logic [31:0] RX_START_DATA_ADDR = 32'h0000_0904;
  localparam logic [31:0] RX_NEXT_SEL_ADDR   = 32'h0000_0910;
  localparam logic [31:0] RX_NEXT_DATA_ADDR  = 32'h0000_0914;
  localparam logic [31:0] RX_HIGH_SEL_ADDR   = 32'h0000_0920;
  localparam logic [31:0] RX_HIGH_DATA_ADDR  = 32'h0000_0924;
  localparam logic [31:0] TX_START_SEL_ADDR  = 32'h0000_0980;
  localparam logic [31:0] TX_START_DATA_ADDR = 32'h0000_0984;

  // table numbers, one select/data pair each
  localparam int         NUM_TABLES   = 4;
  localparam logic [1:0] TBL_RX_START = 2'h0;
  localparam logic [1:0] TBL_RX_NEXT  = 2'h1;
  localparam logic [1:0] TBL_RX_HIGH  = 2'h2;
  localparam logic [1:0] TBL_TX_START = 2'h3;

  // field layout
  localparam int          BUSY_BIT      = 15;
  localparam int          DIR_BIT       = 14;
  localparam int          CHAN_W        = 8;
  localparam int          BLOCK_W       = 10;
  localparam int          NUM_CHAN      = 256;
  localparam int          NUM_BLOCKS    = 1024;
  localparam logic [9:0]  CHAN_MASK     = 10'h0FF;
  localparam logic [9:0]  BLOCK_MASK    = 10'h3FF;
  localparam logic [9:0]  COUNT_ZERO    = 10'h000;
  localparam logic [9:0]  COUNT_STEP    = 10'h001;
  localparam logic [15:0] SELECT_RESET  = 16'h0000;
  localparam logic        HRESP_OKAY    = 1'b0;

  typedef enum logic [1:0] {
    BUS_IDLE      = 2'b00,
    BUS_WRITE     = 2'b01,
    BUS_READ_WAIT = 2'b10,
    BUS_READ_DONE = 2'b11
  } bus_state_type;

  typedef struct packed {
    logic        hit;
    logic        is_data;
    logic [1:0]  tbl;
  } slot_type;

  typedef struct packed {
    logic        hsel;
    logic [31:0] haddr;
    logic [1:0]  htrans;
    logic        hwrite;
    logic [2:0]  hsize;
    logic [31:0] hwdata;
    logic        hready;
  } ahb_in_type;

  typedef struct packed {
    logic        hreadyout;
    logic        hresp;
    logic [31:0] hrdata;
  } ahb_out_type;

  typedef struct packed {
    logic        block_done;
    logic        eof;
    logic [7:0]  channel;
  } rx_event_type;

  typedef struct packed {
    logic        block_done;
    logic [7:0]  channel;
  } tx_event_type;

  typedef struct packed {
    logic        req;
    logic [7:0]  channel;
  } rx_xfer_type;

endpackage

// *** fifo_link_chk.sv ***
// concurrent checks on the ports of the link-list register bank
module fifo_link_chk
  import fifo_link_pkg::*;
(
  // clock and reset
  input wire logic                         hclk,
  input wire logic                         hresetn,
  // register bus
  input wire fifo_link_pkg::ahb_in_type    ahb_in,
  input wire fifo_link_pkg::ahb_out_type   ahb_out,
  // receive engine
  input wire fifo_link_pkg::rx_event_type  rx_event,
  input wire logic [7:0]                   rx_lookup_channel,
  input wire logic [9:0]                   rx_lookup_block,
  input wire fifo_link_pkg::rx_xfer_type   rx_xfer,
  // transmit engine
  input wire fifo_link_pkg::tx_event_type  tx_event,
  input wire logic [7:0]                   tx_lookup_channel,
  input wire logic [9:0]                   tx_lookup_block
);
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  logic take;
  assign take = ahb_in.hsel & ahb_in.htrans[1] & ahb_out.hreadyout;
  a_resp_okay: assert property (ahb_out.hresp == HRESP_OKAY)
    else $error("bus answered with an error response");
  a_write_no_wait: assert property (
    take & ahb_in.hwrite |=> ahb_out.hreadyout)
    else $error("write data phase was stretched");
  a_read_one_wait: assert property (
    take & !ahb_in.hwrite |=> !ahb_out.hreadyout ##1 ahb_out.hreadyout)
    else $error("read did not take exactly one wait state");
  a_wait_from_read: assert property (
    $fell(ahb_out.hreadyout) |-> $past(take & !ahb_in.hwrite))
    else $error("wait state without a read");
  a_rdata_held: assert property (
    ahb_out.hreadyout |=> $stable(ahb_out.hrdata))
    else $error("read data moved outside a read");
  a_unused_zero: assert property (
    ahb_out.hrdata[31:16] == 16'h0000 && ahb_out.hrdata[13:10] == 4'h0)
    else $error("unused read bits not zero");
  a_req_has_cause: assert property (
    rx_xfer.req |-> $past(rx_event.block_done | rx_event.eof))
    else $error("transfer request without an engine event");
  a_eof_requests: assert property (
    rx_event.eof |=> rx_xfer.req
      && rx_xfer.channel == $past(rx_event.channel))
    else $error("end of frame gave no transfer request");
  cover property (rx_xfer.req);
  cover property (take & !ahb_in.hwrite);
  cover property (rx_event.eof);
endmodule

bind fifo_link_list_indirect_config fifo_link_chk fifo_link_chk_i (
  .hclk(hclk), .hresetn(hresetn), .ahb_in(ahb_in), .ahb_out(ahb_out),
  .rx_event(rx_event), .rx_lookup_channel(rx_lookup_channel),
  .rx_lookup_block(rx_lookup_block), .rx_xfer(rx_xfer),
  .tx_event(tx_event), .tx_lookup_channel(tx_lookup_channel),
  .tx_lookup_block(tx_lookup_block)
);

// *** tb_top.sv ***
// self-checking bench for the link-list indirect register bank
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  import fifo_link_pkg::*;
  logic         hclk = 1'b0;
  logic         hresetn = 1'b0;
  ahb_in_type   ai;
  ahb_out_type  ao;
  rx_event_type re;
  tx_event_type te;
  rx_xfer_type  rx;
  logic [7:0]   rlc, tlc;
  logic [9:0]   rlb, tlb;
  int           bad_count = 0;
  int           n_compared = 0;
  int           m[4][1024];
  int           c, b, cnt;
  int           last_ch = 0;
  logic [31:0]  sel_a[4] = '{RX_START_SEL_ADDR, RX_NEXT_SEL_ADDR,
                             RX_HIGH_SEL_ADDR, TX_START_SEL_ADDR};
  int           evs[6] = '{1, 1, 1, 1, 2, 1};

  always #50 hclk = ~hclk;

  // hready of the bus is the one slave's hreadyout
  fifo_link_list_indirect_config fifo_link_list_indirect_config_i (
    .hclk              (hclk),
    .hresetn           (hresetn),
    .ahb_in            ({ai[71:1], ao.hreadyout}),
    .ahb_out           (ao),
    .rx_event          (re),
    .rx_lookup_channel (rlc),
    .rx_lookup_block   (rlb),
    .rx_xfer           (rx),
    .tx_event          (te),
    .tx_lookup_channel (tlc),
    .tx_lookup_block   (tlb)
  );

  task automatic test_done();
    $display("compared %0d mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  task automatic chk(input logic [31:0] g, e);
    n_compared++;
    if (g !== e) begin
      bad_count++;
      $display("BAD %0t got %h expected %h", $time, g, e);
    end
  endtask

  // hreadyout is looked at mid-cycle, then the edge that samples it passes
  task automatic rdy(output logic [31:0] d);
    do @(negedge hclk); while (ao.hreadyout !== 1'b1);
    d = ao.hrdata;
    @(posedge hclk);
  endtask

  task automatic xfer(input logic w, input logic [31:0] a, wd,
                      output logic [31:0] d);
    ai.hsel <= 1'b1;
    ai.haddr <= a;
    ai.hwrite <= w;
    ai.htrans <= 2'b10;
    ai.hsize <= 3'b010;
    rdy(d);
    ai.hsel <= 1'b0;
    ai.htrans <= 2'b00;
    ai.hwdata <= wd;
    rdy(d);
  endtask

  // one indirect access: data, select, poll busy, fetch result
  task automatic ind(input int t, dir, idx, v);
    logic [31:0] sa, d;
    sa = sel_a[t];
    xfer(1'b1, sa + 4, 32'(dir ? ~v & 'h3FF : v), d);
    xfer(1'b1, sa, 32'((dir << 14) | idx), d);
    if (dir == 0)
      m[t][idx] = v;
    repeat (20) begin
      xfer(1'b0, sa, 0, d);
      if (d[15] === 1'b0)
        break;
    end
    chk(d, 32'((dir << 14) | idx));
    if (dir != 0) begin
      xfer(1'b0, sa + 4, 0, d);
      chk(d, 32'(m[t][idx]));
    end
  endtask

  task automatic ev(input int e);
    logic x;
    re <= {e[0], e[1], c[7:0]};
    @(posedge hclk);
    re <= '0;
    if (e[0])
      m[0][c] = m[1][m[0][c]];
    cnt += e[0];
    x = e[1] || cnt >= m[2][c];
    if (x) begin
      cnt = 0;
      last_ch = c;
    end
    @(negedge hclk);
    chk(32'({rx.req, rx.channel}), 32'({x, last_ch[7:0]}));
    @(negedge hclk);
    chk(32'({rx.req, rlb}), 32'(m[0][c]));
    @(posedge hclk);
  endtask

  initial begin
    logic [31:0] d;
    int idx, v, lim;
    ai = '0;
    re = '0;
    te = '0;
    rlc = 8'h00;
    tlc = 8'h00;
    void'($urandom(64));
    repeat (6) @(posedge hclk);
    hresetn <= 1'b1;
    for (int t = 0; t < 4; t++)
      for (int o = 0; o < 8; o += 4) begin
        xfer(1'b0, sel_a[t] + o, 0, d);
        chk(d, 0);
      end
    // unmapped hole drops writes and reads zero
    xfer(1'b1, 32'h0000_0908, 32'h0000_03FF, d);
    xfer(1'b0, 32'h0000_0908, 0, d);
    chk(d, 0);
    for (int t = 0; t < 4; t++)
      for (int k = 0; k < 3; k++) begin
        lim = (t == 1) ? 1023 : 255;
        idx = (k == 0) ? 0 : (k == 1) ? lim : $urandom_range(lim);
        v = $urandom_range(1023);
        if (t == 1 && v == idx)
          v = idx ^ 1;
        if (t == 2 && v == 0)
          v = 1;
        ind(t, 0, idx, v);
        ind(t, 1, idx, 0);
      end
    // four-block ring, mark three, then blocks and an early frame end
    c = $urandom_range(255);
    b = $urandom_range(1019);
    rlc <= c[7:0];
    for (int k = 0; k < 4; k++)
      ind(1, 0, b + k, b + (k + 1) % 4);
    ind(2, 0, c, 3);
    ind(0, 0, c, b);
    cnt = 0;
    foreach (evs[i])
      ev(evs[i]);
    ind(0, 1, c, 0);
    // transmit pointer wraps past the last block
    tlc <= 8'hFF;
    ind(3, 0, 255, 1023);
    te <= {1'b1, 8'hFF};
    @(posedge hclk);
    te <= '0;
    m[3][255] = 0;
    repeat (2) @(negedge hclk);
    chk(32'(tlb), 0);
    @(posedge hclk);
    ind(3, 1, 255, 0);
    test_done();
  end

  initial begin
    repeat (20000) @(posedge hclk);
    bad_count++;
    test_done();
  end
endmodule
